// File: include/comparator_regs_pkg.sv
// Register map, field layout, timing and carriers of the comparator register bank
// Assumes a single core_clk domain shared with the comparator cores and event fabric
package comparator_regs_pkg;

   // ============================================================
   // Sizes
   localparam int unsigned ADDR_W = 6;   // Byte address width
   localparam int unsigned N_CH = 4;     // Comparator channels
   localparam int unsigned N_WIN = 2;    // Window pairs
   localparam int unsigned N_IRQ = 6;    // Interrupt sources
   localparam int unsigned N_EV_DEF = 2; // Event lines per channel

   // ============================================================
   // Byte offsets
   localparam logic [5:0] OFS_CONTROL_MAIN = 6'h00;
   localparam logic [5:0] OFS_SINGLE_SHOT_START = 6'h01;
   localparam logic [5:0] OFS_EVENT_ROUTING_LO = 6'h02;
   localparam logic [5:0] OFS_EVENT_ROUTING_HI = 6'h03;
   localparam logic [5:0] OFS_IRQ_ENABLE_CLEAR = 6'h04;
   localparam logic [5:0] OFS_IRQ_ENABLE_SET = 6'h05;
   localparam logic [5:0] OFS_IRQ_FLAGS = 6'h06;
   localparam logic [5:0] OFS_SYNC_BUSY_FLAGS = 6'h20;

   // ============================================================
   // Field positions
   localparam int unsigned CTRL_SOFTWARE_RESET_BIT = 0;   // Software reset
   localparam int unsigned CTRL_ENABLE_BIT = 1;  // Global enable
   localparam int unsigned EV_CH_EO_LSB = 0;     // Channel event output enables
   localparam int unsigned EV_WIN_EO_LSB = 4;    // Window event output enables
   localparam int unsigned EV_TRIG_LSB = 8;      // Event input trigger enables
   localparam int unsigned EV_INV_LSB = 12;      // Event input inversion
   localparam int unsigned IRQ_CH_LSB = 0;       // Channel interrupts
   localparam int unsigned IRQ_WIN_LSB = 4;      // Window interrupts

   // ============================================================
   // Reset values and timing
   localparam logic [15:0] RST_EVENT_ROUTING = 16'h0000;
   localparam logic [5:0] RST_IRQ = 6'h00;
   localparam int unsigned SYNC_CYCLES_DEF = 3; // Peripheral-side sync delay

   // Access size of one bus transfer
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'b00,
      SIZE_HALF = 2'b01,
      SIZE_WORD = 2'b10
   } access_size_t;

   // Synchroniser sequence, Gray along idle->enable->reset
   typedef enum logic [1:0] {
      SYNC_IDLE = 2'b00,
      SYNC_EN = 2'b01,
      SYNC_RST = 2'b11
   } sync_state_t;

   // Register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      access_size_t size;
      logic [31:0] wdata;
      logic we;
      logic re;
   } bus_req_t;

   // Whole state of the bank
   typedef struct packed {
      logic enable;               // Enable as written
      logic periph_en;            // Enable as reached by the core
      sync_state_t sync;          // Sync sequence
      logic [3:0] cnt;            // Sync countdown
      logic [15:0] event_routing_control;        // Event routing control
      logic [N_IRQ-1:0] inten;    // Shared interrupt enables
      logic [N_IRQ-1:0] flags;    // Interrupt flags
      logic [N_CH-1:0] ev_prev;   // Previous event level
      logic [N_CH-1:0] start;     // Comparison trigger pulses
      logic [N_CH-1:0] ch_ev;     // Channel event outputs
      logic [N_WIN-1:0] win_ev;   // Window event outputs
      logic [31:0] rdata;         // Read data
   } state_t;

endpackage : comparator_regs_pkg

// File: verilog/comparator_control_register_bank.sv
// Control register bank of a four-channel analog comparator
// Assumes bus, guard, event fabric and comparator cores all run on core_clk
// Contract
// R1: Byte, half and word accesses, any lane
// R2: Guard lock blocks protected register writes
// R3: Event routing writable only while disabled
// R4: Enable reads back, busy until applied
// R5: Channel also needs own enable
// R6: Software reinitialises by reset, not toggling
// R7: Software reset clears all, disables block
// R8: Reset write discards other written fields
// R9: Reset bit and busy clear together
// R10: Start launches only single-shot enabled channel
// R11: Start bits always read zero
// R12: Inversion bit inverts channel event input
// R13: Trigger enable lets events start comparison
// R14: Any connected event fires the action
// R15: Window event outputs gated by enables
// R16: Channel event outputs gated by enables
// R17: Enable-clear reads state, ones disable
// R18: Set and clear share enable state
// R19: Enable-set window 0 bit enables
// R20: Other enable-set bits behave alike
// R21: Request while flag and enable set
// R22: Ones clear flags, zeros ignored
//
// The address-and-strobe port was left to the implementer.
module comparator_control_register_bank
   import comparator_regs_pkg::*;
#(
   parameter int unsigned SYNC_CYCLES = SYNC_CYCLES_DEF,
   parameter int unsigned N_EV = N_EV_DEF
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire bus_req_t req,
   output logic [31:0] reg_rdata,
   input wire logic guard_lock,
   input wire logic [N_CH-1:0] channel_enable,
   input wire logic [N_CH-1:0] channel_single,
   input wire logic [N_CH-1:0] channel_state,
   input wire logic [N_WIN-1:0] window_inside,
   input wire logic [N_IRQ-1:0] irq_set_pulse,
   input wire logic [N_EV*N_CH-1:0] event_in,
   output logic [N_CH-1:0] comparison_trigger,
   output logic [N_CH-1:0] channel_event_out,
   output logic [N_WIN-1:0] window_event_out,
   output logic periph_enabled,
   output logic irq_request
);

   // ============================================================
   // Elaboration checks
   if (SYNC_CYCLES < 1 || SYNC_CYCLES > 15 || N_EV < 1)
   begin : g_bad_param
      $error("Unsupported parameter value");
   end

   localparam logic [3:0] SYNC_LOAD = 4'(SYNC_CYCLES);

   // ============================================================
   // Helpers

   // Byte count of an access
   function automatic logic [2:0] size_len(access_size_t sz);
      unique case (sz)
         SIZE_WORD: return 3'd4;
         SIZE_HALF: return 3'd2;
         default: return 3'd1;
      endcase
   endfunction : size_len

   // Hit flag and lane of a target byte within an access
   function automatic logic [2:0] lane_hit(bus_req_t r, logic [5:0] tgt);
      logic [6:0] diff;
      diff = {1'b0, tgt} - {1'b0, r.addr};
      if (!diff[6] && diff < {4'b0000, size_len(r.size)})
         return {1'b1, diff[1:0]};
      return 3'b000;
   endfunction : lane_hit

   // Write data byte on a lane
   function automatic logic [7:0] lane_byte(logic [31:0] d, logic [1:0] lane);
      return d[{lane, 3'b000} +: 8];
   endfunction : lane_byte

   // Read value of one byte address
   function automatic logic [7:0] reg_byte(state_t s, logic [5:0] tgt);
      unique case (tgt)
         OFS_CONTROL_MAIN:
            return {6'b000000, s.enable, s.sync == SYNC_RST};
         OFS_EVENT_ROUTING_LO: return s.event_routing_control[7:0];
         OFS_EVENT_ROUTING_HI: return s.event_routing_control[15:8];
         OFS_IRQ_ENABLE_CLEAR, OFS_IRQ_ENABLE_SET: return {2'b00, s.inten};
         OFS_IRQ_FLAGS: return {2'b00, s.flags};
         OFS_SYNC_BUSY_FLAGS:
            return {6'b000000, s.sync == SYNC_EN, s.sync == SYNC_RST};
         default: return 8'h00; // Start bits, unmapped
      endcase
   endfunction : reg_byte

   // ============================================================
   // State
   state_t s_q; // Registered state
   state_t s_d; // Next state

   logic [2:0] h_ctrl, h_start, h_ev_lo, h_ev_hi, h_iec, h_ies, h_flag; // Lane hits per byte
   logic wr_ok; // Write accepted at all
   logic software_reset_req; // Software reset written
   logic rst_done; // Reset sequence completes
   logic ev_locked; // Event routing enable-protected
   logic [N_IRQ-1:0] flag_clr; // Flags cleared by write
   logic [N_CH-1:0] sw_trig; // Start strobes written
   logic [N_CH-1:0] ev_lvl; // Combined event level
   logic [N_CH-1:0] ev_trig; // Event-caused starts

   // Next-state logic
   always_comb
   begin
      s_d = s_q;
      s_d.rdata = '0;
      flag_clr = '0;
      sw_trig = '0;
      rst_done = 1'b0;
      h_ctrl = lane_hit(req, OFS_CONTROL_MAIN);
      h_start = lane_hit(req, OFS_SINGLE_SHOT_START);
      h_ev_lo = lane_hit(req, OFS_EVENT_ROUTING_LO);
      h_ev_hi = lane_hit(req, OFS_EVENT_ROUTING_HI);
      h_iec = lane_hit(req, OFS_IRQ_ENABLE_CLEAR);
      h_ies = lane_hit(req, OFS_IRQ_ENABLE_SET);
      h_flag = lane_hit(req, OFS_IRQ_FLAGS);
      // Writes are ignored while a reset is pending
      wr_ok = req.we && s_q.sync != SYNC_RST;
      software_reset_req = wr_ok && h_ctrl[2] && !guard_lock // R2
         && 1'(lane_byte(req.wdata, h_ctrl[1:0]) >> CTRL_SOFTWARE_RESET_BIT); // R7
      ev_locked = s_q.enable || s_q.periph_en;

      // Sync sequencer
      unique case (s_q.sync)
         SYNC_IDLE: ; // Nothing pending
         SYNC_EN:
         begin
            if (s_q.cnt == 4'h1)
            begin
               s_d.periph_en = s_q.enable; // R4
               s_d.sync = SYNC_IDLE;
            end
            else
               s_d.cnt = s_q.cnt - 4'h1;
         end
         SYNC_RST:
         begin
            // Countdown; the final cycle clears everything below
            rst_done = s_q.cnt == 4'h1; // R9
            s_d.cnt = s_q.cnt - 4'h1;
         end
         default:
            s_d.sync = SYNC_IDLE; // Illegal code recovers
      endcase

      // Register writes
      if (software_reset_req)
      begin
         // Reset wins, rest of the access dropped
         s_d.sync = SYNC_RST; // R8
         s_d.cnt = SYNC_LOAD;
      end
      else if (wr_ok)
      begin
         // Global enable
         if (h_ctrl[2] && !guard_lock) // R2
         begin
            s_d.enable = 1'(lane_byte(req.wdata, h_ctrl[1:0]) >> CTRL_ENABLE_BIT); // R4
            s_d.sync = SYNC_EN;
            s_d.cnt = SYNC_LOAD;
         end
         // Start strobes, never stored
         if (h_start[2])
            sw_trig = N_CH'(lane_byte(req.wdata, h_start[1:0]));
         // Event routing, locked while enabled
         if (h_ev_lo[2] && !guard_lock && !ev_locked) // R3
            s_d.event_routing_control[7:0] = lane_byte(req.wdata, h_ev_lo[1:0]);
         if (h_ev_hi[2] && !guard_lock && !ev_locked) // R3
            s_d.event_routing_control[15:8] = lane_byte(req.wdata, h_ev_hi[1:0]);
         // Shared enables: clear then set
         if (h_iec[2] && !guard_lock)
            s_d.inten = s_d.inten & ~N_IRQ'(lane_byte(req.wdata, h_iec[1:0])); // R17 R18
         if (h_ies[2] && !guard_lock)
            s_d.inten = s_d.inten | N_IRQ'(lane_byte(req.wdata, h_ies[1:0])); // R19 R20 R18
         // Flag clear by ones
         if (h_flag[2])
            flag_clr = N_IRQ'(lane_byte(req.wdata, h_flag[1:0])); // R22
      end

      // Flags: a set in the clear cycle wins
      s_d.flags = (s_q.flags & ~flag_clr) | irq_set_pulse; // R22

      // Event inputs: any line fires, then invert
      for (int c = 0; c < N_CH; c++)
      begin
         ev_lvl[c] = 1'b0;
         for (int e = 0; e < N_EV; e++)
            ev_lvl[c] = ev_lvl[c] | event_in[e * N_CH + c]; // R14
         ev_lvl[c] = ev_lvl[c] ^ s_q.event_routing_control[EV_INV_LSB + c]; // R12
      end
      ev_trig = ev_lvl & ~s_q.ev_prev
         & s_q.event_routing_control[EV_TRIG_LSB +: N_CH]; // R13 R14
      s_d.ev_prev = ev_lvl;

      // Comparison launch
      s_d.start = ((sw_trig & channel_single) | ev_trig) // R10
         & channel_enable & {N_CH{s_q.periph_en}}; // R5

      // Event outputs
      s_d.ch_ev = channel_state & s_q.event_routing_control[EV_CH_EO_LSB +: N_CH]
         & {N_CH{s_q.periph_en}}; // R16
      s_d.win_ev = window_inside & s_q.event_routing_control[EV_WIN_EO_LSB +: N_WIN]
         & {N_WIN{s_q.periph_en}}; // R15

      // Completed reset returns every field except read data to zero
      if (rst_done)
         s_d = '0; // R7 R9

      // Read data, one cycle after the strobe
      for (int k = 0; k < 4; k++)
      begin
         if (req.re && 3'(k) < size_len(req.size)) // R1
            s_d.rdata[8 * k +: 8] = reg_byte(s_q, 6'(req.addr + 6'(k))); // R11
      end
   end

   // State register with clock enable
   always_ff @(posedge core_clk)
   begin
      if (rst)
         s_q <= '0;
      else if (clk_en)
         s_q <= s_d;
   end

   // ============================================================
   // Outputs
   assign reg_rdata = s_q.rdata;
   assign comparison_trigger = s_q.start;
   assign channel_event_out = s_q.ch_ev;
   assign window_event_out = s_q.win_ev;
   assign periph_enabled = s_q.periph_en;
   assign irq_request = |(s_q.flags & s_q.inten); // R21

   // ============================================================
   // Assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Write of any size to control with reset bit
   sequence s_software_reset_wr;
      clk_en && req.we && req.addr == OFS_CONTROL_MAIN
         && req.wdata[CTRL_SOFTWARE_RESET_BIT] && !guard_lock && s_q.sync != SYNC_RST;
   endsequence

   property p_guard_ctrl;
      clk_en && req.we && guard_lock && s_q.sync == SYNC_IDLE
         |=> s_q.enable == $past(s_q.enable) && s_q.sync == SYNC_IDLE;
   endproperty
   a_guard_ctrl: assert property (p_guard_ctrl) // R2
      else $error("Locked write changed control");

   property p_event_routing_control_locked;
      clk_en && (s_q.enable || s_q.periph_en) && s_q.sync != SYNC_RST
         |=> $stable(s_q.event_routing_control);
   endproperty
   a_event_routing_control_locked: assert property (p_event_routing_control_locked) // R3
      else $error("Event routing written while enabled");

   property p_enable_busy;
      clk_en && req.we && req.addr == OFS_CONTROL_MAIN && req.size == SIZE_BYTE
         && !req.wdata[CTRL_SOFTWARE_RESET_BIT] && !guard_lock && s_q.sync != SYNC_RST
         |=> s_q.sync == SYNC_EN && s_q.enable == $past(req.wdata[CTRL_ENABLE_BIT]);
   endproperty
   a_enable_busy: assert property (p_enable_busy) // R4
      else $error("Enable write not busy or not read back");

   property p_not_enabled;
      clk_en && !s_q.periph_en |=> comparison_trigger == '0;
   endproperty
   a_not_enabled: assert property (p_not_enabled) // R5
      else $error("Comparison launched while disabled");

   property p_software_reset_discard;
      s_software_reset_wr |=> s_q.sync == SYNC_RST && s_q.enable == $past(s_q.enable);
   endproperty
   a_software_reset_discard: assert property (p_software_reset_discard) // R8
      else $error("Reset write did not discard other fields");

   property p_software_reset_done;
      clk_en && s_q.sync == SYNC_RST && s_q.cnt == 4'h1
         |=> s_q.event_routing_control == RST_EVENT_ROUTING && s_q.inten == RST_IRQ
            && !s_q.periph_en && !s_q.enable && s_q.sync == SYNC_IDLE;
   endproperty
   a_software_reset_done: assert property (p_software_reset_done) // R7
      else $error("Software reset left state behind");

   property p_software_reset_read;
      clk_en && req.re && req.addr == OFS_CONTROL_MAIN && s_q.sync == SYNC_RST
         |=> reg_rdata[CTRL_SOFTWARE_RESET_BIT];
   endproperty
   a_software_reset_read: assert property (p_software_reset_read) // R9
      else $error("Reset bit not read as one while pending");

   property p_sw_start;
      clk_en && s_q.periph_en && req.we && req.addr == OFS_SINGLE_SHOT_START
         && req.size == SIZE_BYTE && s_q.sync != SYNC_RST
         |=> (comparison_trigger & $past(req.wdata[3:0] & channel_enable & channel_single))
            == $past(req.wdata[3:0] & channel_enable & channel_single);
   endproperty
   a_sw_start: assert property (p_sw_start) // R10
      else $error("Start strobe did not launch");

   property p_start_zero;
      clk_en && req.re && req.addr == OFS_SINGLE_SHOT_START && req.size == SIZE_BYTE
         |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_start_zero: assert property (p_start_zero) // R11
      else $error("Start bits read nonzero");

   property p_ev_off;
      clk_en && !req.we && s_q.event_routing_control[EV_TRIG_LSB +: N_CH] == '0
         |=> comparison_trigger == '0;
   endproperty
   a_ev_off: assert property (p_ev_off) // R13
      else $error("Event started a disabled channel");

   property p_ch_eo;
      clk_en |=> (channel_event_out & ~$past(s_q.event_routing_control[EV_CH_EO_LSB +: N_CH])) == '0;
   endproperty
   a_ch_eo: assert property (p_ch_eo) // R16
      else $error("Channel event without enable");

   property p_set_clear;
      clk_en && req.we && req.addr == OFS_IRQ_ENABLE_CLEAR && req.size == SIZE_BYTE
         && !guard_lock && s_q.sync != SYNC_RST
         |=> (s_q.inten & $past(req.wdata[N_IRQ-1:0])) == '0;
   endproperty
   a_set_clear: assert property (p_set_clear) // R17
      else $error("Enable clear did not disable");

   property p_flag_set_wins;
      clk_en && |irq_set_pulse && s_q.sync != SYNC_RST
         |=> (s_q.flags & $past(irq_set_pulse)) == $past(irq_set_pulse);
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) // R22
      else $error("Flag set lost");

   property p_irq_hold;
      clk_en && irq_request && !req.we && s_q.sync != SYNC_RST ##1 clk_en
         |-> irq_request;
   endproperty
   a_irq_hold: assert property (p_irq_hold) // R21
      else $error("Request dropped without cause");

   cover property (s_software_reset_wr ##[1:20] s_q.sync == SYNC_IDLE);
   cover property (clk_en && |ev_trig ##1 |comparison_trigger);
   cover property (!irq_request ##1 irq_request);

endmodule : comparator_control_register_bank

// File: dv/far_side_model.sv
// Far-side model: comparator cores and event channels of the bank
// Assumes one core_clk; the bench asks for event pulses by fire
module far_side_model
   import comparator_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic fire,
   input wire logic [2:0] line,
   input wire logic [3:0] hold,
   output logic [N_EV_DEF*N_CH-1:0] event_in,
   output logic [N_CH-1:0] channel_state,
   output logic [N_WIN-1:0] window_inside
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left_q; // Cycles the pulse still stands

   initial
   begin
      event_in = 8'h00;
      channel_state = 4'h0;
      window_inside = 2'h0;
      left_q = 4'h0;
   end

   // ============================================================
   // Event pulse on one line, held for a chosen number of cycles
   always @(posedge core_clk)
   begin
      if (fire)
      begin
         event_in <= 8'h01 << line;
         left_q <= hold;
      end
      else if (left_q > 4'h1)
         left_q <= left_q - 4'h1;
      else
      begin
         // Released line drops back to idle
         left_q <= 4'h0;
         event_in <= 8'h00;
      end
      // Comparator and window status move every cycle
      channel_state <= 4'($urandom);
      window_inside <= 2'($urandom);
   end
endmodule : far_side_model

// File: dv/test_comparator_control_register_bank.sv
// Self-checking bench of the comparator register bank
// Assumes the far-side model is compiled before this file
module test_comparator_control_register_bank
   import comparator_regs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SYNC = 6; // Sync delay used for this run
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   bus_req_t req = '0;
   logic [31:0] reg_rdata;
   logic guard_lock = 1'b0;
   logic [3:0] ch_en = 4'h0;
   logic [3:0] ch_single = 4'h0;
   logic [3:0] ch_state;
   logic [1:0] win_in;
   logic [5:0] irq_set = 6'h00;
   logic [7:0] ev_in;
   logic [3:0] trig;
   logic [3:0] ch_ev;
   logic [1:0] win_ev;
   logic periph_en;
   logic irq_req;
   logic fire = 1'b0;
   logic [2:0] line = 3'h0;
   logic [3:0] hold = 4'h1;
   logic [3:0] trig_seen;
   logic [31:0] rd_seen;
   int failures = 0;
   int n_checks = 0;
   int evc = 0; // Model of event routing
   int inten = 0; // Model of shared enables
   int flags = 0; // Model of flags
   int k, v, c, cnt, any;

   always #12.5 core_clk = ~core_clk;

   comparator_control_register_bank #(.SYNC_CYCLES(SYNC)) i_dut (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .req(req), .reg_rdata(reg_rdata),
      .guard_lock(guard_lock), .channel_enable(ch_en), .channel_single(ch_single),
      .channel_state(ch_state), .window_inside(win_in), .irq_set_pulse(irq_set),
      .event_in(ev_in), .comparison_trigger(trig), .channel_event_out(ch_ev),
      .window_event_out(win_ev), .periph_enabled(periph_en), .irq_request(irq_req));

   far_side_model i_far (
      .core_clk(core_clk), .fire(fire), .line(line), .hold(hold), .event_in(ev_in),
      .channel_state(ch_state), .window_inside(win_in));

   // ============================================================
   // Checking and closing
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] e);
      n_checks++;
      if (seen !== e)
      begin
         failures++;
         $display("[ERR] %s exp %h seen %h", n, e, seen);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   // ============================================================
   // One bus cycle; keeps read data and trigger of the next cycle
   task automatic bus(input logic w, input logic [5:0] a, input access_size_t s,
                      input logic [31:0] d);
      @(posedge core_clk);
      req <= '{addr: a, size: s, wdata: d, we: w, re: !w};
      @(posedge core_clk);
      req.we <= 1'b0;
      req.re <= 1'b0;
      #1;
      trig_seen = trig;
      rd_seen = reg_rdata;
   endtask : bus

   task automatic rd(input logic [5:0] a, input access_size_t s, input logic [31:0] e,
                     input string n);
      bus(1'b0, a, s, 32'h0000_0000);
      chk(n, rd_seen, e);
   endtask : rd

   // Bounded wait for the applied enable
   task automatic wait_for(input logic want);
      cnt = 0;
      while (periph_en !== want)
      begin
         @(posedge core_clk);
         #1;
         cnt++;
         if (cnt > 40)
         begin
            chk("periph_enabled", 32'(periph_en), 32'(want));
            results();
         end
      end
   endtask : wait_for

   // ============================================================
   // Main sequence
   initial
   begin
      v = $urandom(91);
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      // Reset values and an unmapped place
      bus(1'b1, 6'h3c, SIZE_WORD, 32'hffff_ffff);
      rd(6'h3c, SIZE_WORD, 32'h0000_0000, "unmapped");
      rd(OFS_CONTROL_MAIN, SIZE_WORD, 32'h0000_0000, "reset word");
      rd(OFS_IRQ_ENABLE_CLEAR, SIZE_HALF, 32'h0000_0000, "reset enables");
      // Shared enables through set and clear
      for (k = 0; k < 8; k++)
      begin
         v = $urandom & 32'h0000_00ff;
         bus(1'b1, OFS_IRQ_ENABLE_SET, SIZE_BYTE, 32'(v));
         inten = inten | (v & 32'h0000_003f);
         rd(OFS_IRQ_ENABLE_CLEAR, SIZE_BYTE, 32'(inten), "enables via clear");
         v = $urandom & 32'h0000_00ff;
         bus(1'b1, OFS_IRQ_ENABLE_CLEAR, SIZE_BYTE, 32'(v));
         inten = inten & ~v;
         rd(OFS_IRQ_ENABLE_SET, SIZE_BYTE, 32'(inten), "enables via set");
      end
      // Flags raise and drop the request
      bus(1'b1, OFS_IRQ_ENABLE_SET, SIZE_BYTE, 32'h0000_002d);
      inten = inten | 32'h0000_002d;
      for (k = 0; k < 6; k++)
      begin
         v = $urandom & 32'h0000_003f;
         @(posedge core_clk);
         irq_set <= 6'(v);
         @(posedge core_clk);
         irq_set <= 6'h00;
         #1;
         flags = flags | v;
         chk("irq set", 32'(irq_req), 32'((flags & inten) != 0));
         v = $urandom & 32'h0000_003f;
         bus(1'b1, OFS_IRQ_FLAGS, SIZE_BYTE, 32'(v));
         flags = flags & ~v;
         rd(OFS_IRQ_FLAGS, SIZE_BYTE, 32'(flags), "flags");
         chk("irq clear", 32'(irq_req), 32'((flags & inten) != 0));
      end
      // Event routing while disabled, by half and by byte
      v = $urandom & 32'h0000_ff3f;
      bus(1'b1, OFS_EVENT_ROUTING_LO, SIZE_HALF, 32'(v));
      rd(OFS_EVENT_ROUTING_LO, SIZE_HALF, 32'(v), "routing half");
      bus(1'b1, OFS_EVENT_ROUTING_HI, SIZE_BYTE, 32'h0000_0057);
      bus(1'b1, OFS_EVENT_ROUTING_LO, SIZE_BYTE, 32'h0000_0035);
      evc = 32'h0000_5735;
      rd(OFS_CONTROL_MAIN, SIZE_WORD, 32'h5735_0000, "word lanes");
      // Guard lock blocks protected writes
      @(posedge core_clk);
      guard_lock <= 1'b1;
      bus(1'b1, OFS_IRQ_ENABLE_CLEAR, SIZE_BYTE, 32'h0000_003f);
      bus(1'b1, OFS_EVENT_ROUTING_LO, SIZE_HALF, 32'h0000_0000);
      bus(1'b1, OFS_CONTROL_MAIN, SIZE_BYTE, 32'h0000_0002);
      rd(OFS_IRQ_ENABLE_CLEAR, SIZE_BYTE, 32'(inten), "locked enables");
      rd(OFS_CONTROL_MAIN, SIZE_WORD, 32'h5735_0000, "locked control");
      @(posedge core_clk);
      guard_lock <= 1'b0;
      // Enable reads back at once, busy until applied
      bus(1'b1, OFS_CONTROL_MAIN, SIZE_BYTE, 32'h0000_0002);
      rd(OFS_CONTROL_MAIN, SIZE_BYTE, 32'h0000_0002, "enable readback");
      rd(OFS_SYNC_BUSY_FLAGS, SIZE_BYTE, 32'h0000_0002, "enable busy");
      wait_for(1'b1);
      rd(OFS_SYNC_BUSY_FLAGS, SIZE_BYTE, 32'h0000_0000, "enable settled");
      bus(1'b1, OFS_EVENT_ROUTING_LO, SIZE_HALF, 32'h0000_0000);
      rd(OFS_EVENT_ROUTING_LO, SIZE_HALF, 32'(evc), "routing protected");
      // Event outputs follow status and enables
      for (k = 0; k < 8; k++)
      begin
         v = ch_state;
         c = win_in;
         @(posedge core_clk);
         #1;
         chk("channel events", 32'(ch_ev), 32'(v & evc & 32'h0000_000f));
         chk("window events", 32'(win_ev), 32'(c & (evc >> 4) & 32'h0000_0003));
      end
      // Start strobes against channel enable and single-shot
      for (k = 0; k < 16; k++)
      begin
         v = $urandom;
         @(posedge core_clk);
         ch_en <= 4'(v);
         ch_single <= 4'(v >> 4);
         bus(1'b1, OFS_SINGLE_SHOT_START, SIZE_BYTE, 32'((v >> 8) & 32'h0000_000f));
         chk("start", 32'(trig_seen), 32'(v & (v >> 4) & (v >> 8) & 32'h0000_000f));
         rd(OFS_SINGLE_SHOT_START, SIZE_BYTE, 32'h0000_0000, "start reads zero");
      end
      // Events on every line, some channels inverted, one not triggering
      @(posedge core_clk);
      ch_en <= 4'hf;
      for (k = 0; k < 8; k++)
      begin
         c = k % 4;
         @(posedge core_clk);
         fire <= 1'b1;
         line <= 3'(k);
         hold <= 4'(1 + ($urandom & 32'h0000_0003));
         @(posedge core_clk);
         fire <= 1'b0;
         cnt = 0;
         any = 0;
         repeat (10)
         begin
            @(posedge core_clk);
            #1;
            cnt = cnt + trig[c];
            any = any | (trig & ~(4'h1 << c));
         end
         chk("event start", 32'(cnt), (c < 3) ? 32'h0000_0001 : 32'h0000_0000);
         chk("event other", 32'(any), 32'h0000_0000);
      end
      // Frozen clock enable drops a write
      @(posedge core_clk);
      clk_en <= 1'b0;
      bus(1'b1, OFS_IRQ_ENABLE_SET, SIZE_BYTE, 32'h0000_003f);
      clk_en <= 1'b1;
      rd(OFS_IRQ_ENABLE_CLEAR, SIZE_BYTE, 32'(inten), "frozen enables");
      // Software reset discards the rest of its write, enable clear too
      @(posedge core_clk);
      ch_single <= 4'hf;
      bus(1'b1, OFS_CONTROL_MAIN, SIZE_WORD, 32'h0000_0f01);
      chk("start discarded", 32'(trig_seen), 32'h0000_0000);
      rd(OFS_SYNC_BUSY_FLAGS, SIZE_BYTE, 32'h0000_0001, "reset busy");
      bus(1'b0, OFS_CONTROL_MAIN, SIZE_BYTE, 32'h0000_0000);
      chk("reset bit", rd_seen, 32'h0000_0003);
      cnt = 0;
      while (rd_seen[0] !== 1'b0 && cnt < 20)
      begin
         bus(1'b0, OFS_SYNC_BUSY_FLAGS, SIZE_BYTE, 32'h0000_0000);
         cnt++;
      end
      chk("reset done", 32'(rd_seen), 32'h0000_0000);
      rd(OFS_CONTROL_MAIN, SIZE_WORD, 32'h0000_0000, "control after reset");
      rd(OFS_IRQ_ENABLE_CLEAR, SIZE_WORD, 32'h0000_0000, "irq after reset");
      chk("outputs after reset", 32'({periph_en, irq_req, ch_ev, win_ev}), 32'h0000_0000);
      results();
   end
endmodule : test_comparator_control_register_bank
